// ### rtl/loss_signal_detector.v
`timescale 1ns/1ps
module loss_signal_detector #(
  parameter CNT_W = 8
) (
  input wire clk_sys,
  input wire rst_n,
  input wire refIn,
  input wire enable,
  input wire [CNT_W-1:0] limit,
  output reg lossOfSignal
);

  reg [2:0] refSync_r;
  reg [CNT_W-1:0] idleCnt_r;
  wire refEdge;

  // Any transition counts as activity, so a stuck-high input also times out.
  assign refEdge = refSync_r[2] ^ refSync_r[1];

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      refSync_r <= 3'h0;
      idleCnt_r <= {CNT_W{1'b0}};
      lossOfSignal <= 1'b0;
    end else begin
      refSync_r <= {refSync_r[1:0], refIn};
      if (!enable || refEdge) begin // [RL21]
        idleCnt_r <= {CNT_W{1'b0}};
        lossOfSignal <= 1'b0;
      end else if (idleCnt_r >= limit) begin
        lossOfSignal <= 1'b1; // [RL20]
      end else begin
        idleCnt_r <= idleCnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // loss_signal_detector

// ### rtl/refclk_select_consts.vh
`ifndef REFCLK_SELECT_CONSTS_VH
`define REFCLK_SELECT_CONSTS_VH

// Serial configuration word layout.
`define CFG_WORD_BITS 32
`define CFG_ADDR_MSB 4
`define CFG_ADDR_LSB 0
`define ADDR_LOCK_PIN_SYNC_HOLDOVER 5'h0c
`define ADDR_STATUS_PINS_REFSEL 5'h0d
`define ADDR_LOSS_TIMEOUT_INPUT 5'h0e

// lock_pin_sync_holdover_cfg fields.
`define LOCK_SRC_MSB 31
`define LOCK_SRC_LSB 27
`define LOCK_TYPE_MSB 26
`define LOCK_TYPE_LSB 24
`define SYNC_LOOP2_BIT 23
`define SYNC_LOOP1_BIT 22
`define TRACK_EN_BIT 8
`define HOLD_MODE_MSB 7
`define HOLD_MODE_LSB 6

// status_pins_refsel_cfg fields.
`define HOLD_SRC_MSB 31
`define HOLD_SRC_LSB 27
`define HOLD_TYPE_MSB 26
`define HOLD_TYPE_LSB 24
`define IN1_SRC_MSB 22
`define IN1_SRC_LSB 20
`define IN0_TYPE_MSB 18
`define IN0_TYPE_LSB 16
`define LOCK_LOSS_DIS_BIT 15
`define IN0_SRC_MSB 14
`define IN0_SRC_LSB 12
`define REF_MODE_MSB 11
`define REF_MODE_LSB 9
`define SEL_POL_BIT 8
`define REF_EN_MSB 7
`define REF_EN_LSB 5

// loss_timeout_input_cfg fields.
`define LOS_TIME_MSB 31
`define LOS_TIME_LSB 30
`define LOS_EN_BIT 28
`define IN1_TYPE_MSB 26
`define IN1_TYPE_LSB 24

// Reset values of the three configuration words.
`define RST_LOCK_PIN_SYNC_HOLDOVER 32'h1b000080
`define RST_STATUS_PINS_REFSEL 32'h230000e0
`define RST_LOSS_TIMEOUT_INPUT 32'h00000000

// Pin IO type codes.
`define IO_PUSH_PULL 3'h3
`define IO_PUSH_PULL_INV 3'h4
`define IO_OPEN_SOURCE 3'h5
`define IO_OPEN_DRAIN 3'h6

// Reference selection modes and the holdover-enabled code.
`define MODE_PIN_SELECT 3'h3
`define MODE_AUTO 3'h4
`define MODE_AUTO_PIN_NEXT 3'h6
`define HOLD_MODE_ENABLED 2'h2

// Loss-of-signal timeouts in picoseconds and the clock period.
`define CLK_PERIOD_PS 10000
`define LOS_TIME0_PS 1200000
`define LOS_TIME1_PS 206000
`define LOS_TIME2_PS 52900
`define LOS_TIME3_PS 23700
`define LOS_CYCLES(ps) (((ps) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

// Readback position of the tracked DAC count.
`define RB_DAC_LSB 14

`endif

// ### rtl/refclk_select_status_pins.v
// Overview of operation
// RL1: Lock pin IO type: 3,4,5,6 output kinds.
// RL2: Forced sync held until chosen loops lock.
// RL3: Software keeps sync qualification cleared then.
// RL4: Tracking bit makes DAC follow loop one.
// RL5: Tracked DAC count always readable while tracking.
// RL6: Holdover field: 1 disables, 2 enables.
// RL7: Holdover pin source select picks status signal.
// RL8: Loop-two R sources need lock source not 2/3.
// RL9: IO type 3 active high, 4 inverted.
// RL10: Holdover pin IO type: 3,4,5,6 output kinds.
// RL11: Input status pins source: LOS, selected, DAC.
// RL12: Input-type status pin ignores its source select.
// RL13: Input-0 status pin IO type incl. inputs.
// RL14: Loop-one lock loss causes switch and holdover.
// RL15: Software disables lock-loss detect in pin mode.
// RL16: Reference mode: manual, pin, auto, auto-pin.
// RL17: Polarity bit inverts the select pin inputs.
// RL18: Only enabled inputs join automatic switching.
// RL19: Auto switching cycles input 0, 1, 2.
// RL20: LOS after selected idle timeout.
// RL21: LOS detection only when enable bit set.
// RL22: Settings change only on complete latched word.
`timescale 1ns/1ps
`include "refclk_select_consts.vh"
module refclk_select_status_pins #(
  parameter DAC_W = 10,
  parameter CNT_W = 8
) (
  input wire clk_sys,
  input wire rst_n,
  input wire cfgClk,
  input wire cfgData,
  input wire cfgLatch,
  input wire [2:0] refClkIn,
  input wire loop1Lock,
  input wire loop2Lock,
  input wire dacLocked,
  input wire dacRail,
  input wire dacLow,
  input wire dacHigh,
  input wire [DAC_W-1:0] loop1TuneCode,
  input wire [3:0] dividerTap,
  input wire status0In,
  input wire status1In,
  output reg syncAssert,
  output reg holdoverActive,
  output reg [1:0] activeInput,
  output reg [DAC_W-1:0] trackedDacCount,
  output reg readbackOut,
  output reg lockPinOut,
  output reg lockPinOe,
  output reg holdoverPinOut,
  output reg holdoverPinOe,
  output reg status0Out,
  output reg status0Oe,
  output reg status1Out,
  output reg status1Oe,
  output wire [2:0] lossOfSignal
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers.

  // Returns {oe, out} for a pin of the given IO type carrying value v.
  function [1:0] pinDrive;
    input [2:0] ioType;
    input v;
    begin
      case (ioType)
        `IO_PUSH_PULL: pinDrive = {1'b1, v}; // [RL9]
        `IO_PUSH_PULL_INV: pinDrive = {1'b1, ~v}; // [RL9]
        `IO_OPEN_SOURCE: pinDrive = {v, 1'b1};
        `IO_OPEN_DRAIN: pinDrive = {~v, 1'b0};
        default: pinDrive = 2'h0; // [RL12]
      endcase
    end
  endfunction

  // Five-bit source select shared by the lock and holdover pins.
  function statusSource;
    input [4:0] sel;
    input [15:0] src;
    begin
      case (sel)
        5'h00: statusSource = 1'b0;
        5'h01: statusSource = src[0];
        5'h02: statusSource = src[1];
        5'h03: statusSource = src[0] & src[1];
        5'h04: statusSource = src[2];
        5'h05: statusSource = src[3];
        5'h07: statusSource = src[4];
        5'h08: statusSource = src[5];
        5'h09: statusSource = src[6];
        5'h0a: statusSource = src[7];
        5'h0b: statusSource = src[8];
        5'h0c: statusSource = src[9];
        5'h0d: statusSource = src[10];
        5'h0e: statusSource = src[11];
        5'h0f: statusSource = src[12];
        5'h10: statusSource = src[13];
        5'h11: statusSource = src[14];
        5'h12: statusSource = src[15];
        default: statusSource = 1'b0;
      endcase
    end
  endfunction

  // Three-bit source select of an input-status pin.
  function inputSource;
    input [2:0] sel;
    input los;
    input chosen;
    begin
      case (sel)
        3'h0: inputSource = 1'b0;
        3'h1: inputSource = los;
        3'h2: inputSource = chosen;
        3'h3: inputSource = dacLocked;
        3'h4: inputSource = dacLow;
        3'h5: inputSource = dacHigh;
        3'h6: inputSource = readbackOut;
        default: inputSource = 1'b0;
      endcase
    end
  endfunction

  // Next enabled input in the fixed cycle 0, 1, 2, 0.
  function [1:0] nextInput;
    input [1:0] cur;
    input [2:0] en;
    reg [1:0] c;
    reg found;
    integer i;
    begin
      c = cur;
      found = 1'b0;
      nextInput = cur;
      for (i = 0; i < 3; i = i + 1) begin
        c = (c == 2'h2) ? 2'h0 : c + 2'h1; // [RL19]
        if (!found && en[c]) begin // [RL18]
          nextInput = c;
          found = 1'b1;
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Serial configuration port.

  reg [31:0] lockCfg_r;
  reg [31:0] pinsCfg_r;
  reg [31:0] losCfg_r;
  reg [31:0] shift_r;
  reg [5:0] bitCnt_r;
  reg [31:0] rbShift_r;
  reg [2:0] cfgSync1_r;
  reg [2:0] cfgSync2_r;
  reg cfgClkD_r;
  reg cfgLatchD_r;
  wire cfgClkRise;
  wire cfgLatchRise;
  wire wordDone;
  wire [4:0] wordAddr;

  assign cfgClkRise = cfgSync2_r[0] & ~cfgClkD_r;
  assign cfgLatchRise = cfgSync2_r[2] & ~cfgLatchD_r;
  assign wordDone = (bitCnt_r == `CFG_WORD_BITS);
  assign wordAddr = shift_r[`CFG_ADDR_MSB:`CFG_ADDR_LSB];

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      cfgSync1_r <= 3'h0;
      cfgSync2_r <= 3'h0;
      cfgClkD_r <= 1'b0;
      cfgLatchD_r <= 1'b0;
      shift_r <= 32'h0;
      bitCnt_r <= 6'h0;
      rbShift_r <= 32'h0;
      lockCfg_r <= `RST_LOCK_PIN_SYNC_HOLDOVER;
      pinsCfg_r <= `RST_STATUS_PINS_REFSEL;
      losCfg_r <= `RST_LOSS_TIMEOUT_INPUT;
    end else begin
      cfgSync1_r <= {cfgLatch, cfgData, cfgClk};
      cfgSync2_r <= cfgSync1_r;
      cfgClkD_r <= cfgSync2_r[0];
      cfgLatchD_r <= cfgSync2_r[2];
      if (cfgLatchRise) begin
        bitCnt_r <= 6'h0;
        // The tracked count is readable whatever the reference mode.
        rbShift_r <= {{(31-`RB_DAC_LSB-DAC_W+1){1'b0}},
          trackedDacCount, {`RB_DAC_LSB{1'b0}}}; // [RL5]
        if (wordDone) begin // [RL22]
          case (wordAddr)
            `ADDR_LOCK_PIN_SYNC_HOLDOVER: lockCfg_r <= shift_r;
            `ADDR_STATUS_PINS_REFSEL: pinsCfg_r <= shift_r;
            `ADDR_LOSS_TIMEOUT_INPUT: losCfg_r <= shift_r;
            default: ;
          endcase
        end
      end else if (cfgClkRise) begin
        shift_r <= {shift_r[30:0], cfgSync2_r[1]};
        rbShift_r <= {rbShift_r[30:0], 1'b0};
        if (!wordDone) begin
          bitCnt_r <= bitCnt_r + 6'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loss of signal on the three reference inputs.

  reg [31:0] losCycles;

  always @* begin
    case (losCfg_r[`LOS_TIME_MSB:`LOS_TIME_LSB]) // [RL20]
      2'h0: losCycles = `LOS_CYCLES(`LOS_TIME0_PS);
      2'h1: losCycles = `LOS_CYCLES(`LOS_TIME1_PS);
      2'h2: losCycles = `LOS_CYCLES(`LOS_TIME2_PS);
      default: losCycles = `LOS_CYCLES(`LOS_TIME3_PS);
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : losGen
      loss_signal_detector #(
        .CNT_W(CNT_W)
      ) losDet (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .refIn(refClkIn[g]),
        .enable(losCfg_r[`LOS_EN_BIT]), // [RL21]
        .limit(losCycles[CNT_W-1:0]),
        .lossOfSignal(lossOfSignal[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Divider taps and their halves.

  reg [3:0] tapD_r;
  reg [3:0] halfTap_r;

  generate
    for (g = 0; g < 4; g = g + 1) begin : halfGen
      always @(posedge clk_sys) begin
        if (!rst_n) begin
          tapD_r[g] <= 1'b0;
          halfTap_r[g] <= 1'b0;
        end else begin
          tapD_r[g] <= dividerTap[g];
          if (dividerTap[g] && !tapD_r[g]) begin
            halfTap_r[g] <= ~halfTap_r[g];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Reference selection, holdover and DAC tracking.

  reg [1:0] stIn0_r;
  reg [1:0] stIn1_r;
  reg loop1LockD_r;
  reg [2:0] losD_r;
  wire [2:0] refMode;
  wire [2:0] refEn;
  wire lockLossEvent;
  wire losActiveEvent;
  wire switchEvent;
  wire [1:0] pinSel;
  wire in0IsInput;
  wire in1IsInput;

  assign refMode = pinsCfg_r[`REF_MODE_MSB:`REF_MODE_LSB];
  assign refEn = pinsCfg_r[`REF_EN_MSB:`REF_EN_LSB];
  assign in0IsInput = pinsCfg_r[`IN0_TYPE_MSB:`IN0_TYPE_LSB] <
    `IO_PUSH_PULL; // [RL13]
  assign in1IsInput = losCfg_r[`IN1_TYPE_MSB:`IN1_TYPE_LSB] < `IO_PUSH_PULL;
  assign pinSel = {in1IsInput & (stIn1_r[1] ^ pinsCfg_r[`SEL_POL_BIT]),
    in0IsInput & (stIn0_r[1] ^ pinsCfg_r[`SEL_POL_BIT])}; // [RL17]
  assign lockLossEvent = loop1LockD_r & ~loop1Lock &
    ~pinsCfg_r[`LOCK_LOSS_DIS_BIT]; // [RL14]
  assign losActiveEvent = lossOfSignal[activeInput] & ~losD_r[activeInput];
  assign switchEvent = lockLossEvent | losActiveEvent;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      stIn0_r <= 2'h0;
      stIn1_r <= 2'h0;
      loop1LockD_r <= 1'b0;
      losD_r <= 3'h0;
      activeInput <= 2'h0;
      holdoverActive <= 1'b0;
      trackedDacCount <= {DAC_W{1'b0}};
      syncAssert <= 1'b0;
    end else begin
      stIn0_r <= {stIn0_r[0], status0In};
      stIn1_r <= {stIn1_r[0], status1In};
      loop1LockD_r <= loop1Lock;
      losD_r <= lossOfSignal;
      case (refMode) // [RL16]
        3'h0, 3'h1, 3'h2: activeInput <= refMode[1:0];
        `MODE_PIN_SELECT: begin
          if (pinSel != 2'h3) begin
            activeInput <= pinSel;
          end
        end
        `MODE_AUTO: begin
          if (switchEvent) begin
            activeInput <= nextInput(activeInput, refEn); // [RL19]
          end
        end
        `MODE_AUTO_PIN_NEXT: begin
          if (switchEvent && pinSel != 2'h3 && refEn[pinSel]) begin
            activeInput <= pinSel;
          end
        end
        default: ;
      endcase
      // Holdover is left once loop one reports lock again.
      if (lockLossEvent && lockCfg_r[`HOLD_MODE_MSB:`HOLD_MODE_LSB] ==
          `HOLD_MODE_ENABLED) begin // [RL6] [RL14]
        holdoverActive <= 1'b1;
      end else if (loop1Lock ||
          lockCfg_r[`HOLD_MODE_MSB:`HOLD_MODE_LSB] != `HOLD_MODE_ENABLED) begin
        holdoverActive <= 1'b0;
      end
      // Freezing during holdover keeps the last good value for the DAC.
      if (lockCfg_r[`TRACK_EN_BIT] && !holdoverActive) begin // [RL4]
        trackedDacCount <= loop1TuneCode;
      end
      syncAssert <= (lockCfg_r[`SYNC_LOOP2_BIT] & ~loop2Lock) |
        (lockCfg_r[`SYNC_LOOP1_BIT] & ~loop1Lock); // [RL2]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status pin drivers.

  wire [15:0] statusSrc;
  wire lockValue;
  wire holdValue;
  wire in0Value;
  wire in1Value;
  wire [1:0] lockDrive;
  wire [1:0] holdDrive;
  wire [1:0] in0Drive;
  wire [1:0] in1Drive;

  assign statusSrc = {halfTap_r[3], dividerTap[3], halfTap_r[2],
    dividerTap[2], halfTap_r[1], dividerTap[1], halfTap_r[0], dividerTap[0],
    dacHigh, dacLow, dacRail, readbackOut, dacLocked, holdoverActive,
    loop2Lock, loop1Lock};
  assign lockValue = statusSource(lockCfg_r[`LOCK_SRC_MSB:`LOCK_SRC_LSB],
    statusSrc);
  assign holdValue = statusSource(pinsCfg_r[`HOLD_SRC_MSB:`HOLD_SRC_LSB],
    statusSrc); // [RL7]
  assign in0Value = inputSource(pinsCfg_r[`IN0_SRC_MSB:`IN0_SRC_LSB],
    lossOfSignal[0], activeInput == 2'h0); // [RL11]
  assign in1Value = inputSource(pinsCfg_r[`IN1_SRC_MSB:`IN1_SRC_LSB],
    lossOfSignal[1], activeInput == 2'h1); // [RL11]
  assign lockDrive = pinDrive(lockCfg_r[`LOCK_TYPE_MSB:`LOCK_TYPE_LSB],
    lockValue); // [RL1]
  assign holdDrive = pinDrive(pinsCfg_r[`HOLD_TYPE_MSB:`HOLD_TYPE_LSB],
    holdValue); // [RL10]
  assign in0Drive = pinDrive(pinsCfg_r[`IN0_TYPE_MSB:`IN0_TYPE_LSB],
    in0Value); // [RL12] [RL13]
  assign in1Drive = pinDrive(losCfg_r[`IN1_TYPE_MSB:`IN1_TYPE_LSB],
    in1Value); // [RL12]

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      readbackOut <= 1'b0;
      {lockPinOe, lockPinOut} <= 2'h0;
      {holdoverPinOe, holdoverPinOut} <= 2'h0;
      {status0Oe, status0Out} <= 2'h0;
      {status1Oe, status1Out} <= 2'h0;
    end else begin
      readbackOut <= rbShift_r[31];
      {lockPinOe, lockPinOut} <= lockDrive;
      {holdoverPinOe, holdoverPinOut} <= holdDrive;
      {status0Oe, status0Out} <= in0Drive;
      {status1Oe, status1Out} <= in1Drive;
    end
  end

endmodule // refclk_select_status_pins

// ### test/board_model.sv
`timescale 1ns/1ps
module board_model (
  input wire clk_sys,
  input wire [2:0] run,
  input wire [1:0] selLevel,
  input wire status0Out,
  input wire status0Oe,
  input wire status1Out,
  input wire status1Oe,
  output reg [2:0] refClkIn,
  output wire status0In,
  output wire status1In
);
  initial refClkIn = 3'h0;
  // A stopped reference freezes at its level, as a dead source would.
  always @(posedge clk_sys) refClkIn <= refClkIn ^ run;
  // A pin the device drives wins; otherwise the board's select shows.
  assign status0In = status0Oe ? status0Out : selLevel[0];
  assign status1In = status1Oe ? status1Out : selLevel[1];
endmodule // board_model

// ### test/refclk_select_checker.sv
`timescale 1ns/1ps
module refclk_select_checker #(
  parameter DAC_W = 10,
  parameter CNT_W = 8
) (
  input wire clk_sys,
  input wire rst_n,
  input wire cfgClk,
  input wire cfgLatch,
  input wire [2:0] refClkIn,
  input wire loop1Lock,
  input wire loop2Lock,
  input wire syncAssert,
  input wire holdoverActive,
  input wire [1:0] activeInput,
  input wire [DAC_W-1:0] trackedDacCount,
  input wire readbackOut,
  input wire [2:0] lossOfSignal
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Counters saturate so a long idle spell never wraps to look short.
  reg [3:0] idle0_r;
  reg [3:0] idle1_r;
  reg [3:0] quiet_r;
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      idle0_r <= 4'h0;
      idle1_r <= 4'h0;
      quiet_r <= 4'h0;
    end else begin
      idle0_r <= $changed(refClkIn[0]) ? 4'h0 : idle0_r + {3'h0, ~&idle0_r};
      idle1_r <= $changed(refClkIn[1]) ? 4'h0 : idle1_r + {3'h0, ~&idle1_r};
      quiet_r <= ($changed(cfgClk) || $changed(cfgLatch)) ? 4'h0 :
        quiet_r + {3'h0, ~&quiet_r};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_sync_needs_unlock: assert property (syncAssert |->
    !$past(loop1Lock) || !$past(loop2Lock)) else $error("sync while locked");
  a_holdover_unlocked: assert property (holdoverActive |->
    !$past(loop1Lock)) else $error("holdover while locked");
  a_holdover_cause: assert property ($rose(holdoverActive) |->
    $past(loop1Lock, 2) && !$past(loop1Lock)) else $error("holdover no fall");
  a_input_index_valid: assert property (activeInput != 2'h3)
    else $error("bad input index");
  a_track_frozen: assert property (
    holdoverActive && $past(holdoverActive) |-> $stable(trackedDacCount))
    else $error("count moved in holdover");
  a_los_idle0: assert property ($rose(lossOfSignal[0]) |->
    idle0_r >= 4'h4) else $error("early loss on input 0");
  a_los_idle1: assert property ($rose(lossOfSignal[1]) |->
    idle1_r >= 4'h4) else $error("early loss on input 1");
  a_readback_quiet: assert property ($changed(readbackOut) |->
    quiet_r < 4'h8) else $error("readback moved unprompted");
  cover property ($rose(holdoverActive));
  cover property ($rose(lossOfSignal[0]));
  cover property ($changed(activeInput));
  cover property (syncAssert);
endmodule // refclk_select_checker

bind refclk_select_status_pins refclk_select_checker #(
  .DAC_W(DAC_W), .CNT_W(CNT_W)) chk_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .cfgClk(cfgClk), .cfgLatch(cfgLatch),
  .refClkIn(refClkIn), .loop1Lock(loop1Lock), .loop2Lock(loop2Lock),
  .syncAssert(syncAssert), .holdoverActive(holdoverActive),
  .activeInput(activeInput), .trackedDacCount(trackedDacCount),
  .readbackOut(readbackOut), .lossOfSignal(lossOfSignal));

// ### test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg clk_sys, rst_n, cfgClk, cfgData, cfgLatch, loop1Lock, loop2Lock;
  reg dacLocked, dacRail, dacLow, dacHigh;
  reg [9:0] tune, old;
  reg [3:0] tap, half;
  reg [2:0] run;
  reg [1:0] selLevel;
  reg [31:0] r, rbSeen;
  wire [2:0] refClkIn, lossOfSignal;
  wire [1:0] activeInput;
  wire [9:0] trackedDacCount;
  wire syncAssert, holdoverActive, readbackOut, lockPinOut, lockPinOe;
  wire holdoverPinOut, holdoverPinOe, status0Out, status0Oe;
  wire status1Out, status1Oe, status0In, status1In;
  integer error_cnt, n_compared, seed, i, j, k, n;
  integer losLim [0:3];
  refclk_select_status_pins refclk_select_status_pins_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .cfgClk(cfgClk), .cfgData(cfgData),
    .cfgLatch(cfgLatch), .refClkIn(refClkIn), .loop1Lock(loop1Lock),
    .loop2Lock(loop2Lock), .dacLocked(dacLocked), .dacRail(dacRail),
    .dacLow(dacLow), .dacHigh(dacHigh), .loop1TuneCode(tune),
    .dividerTap(tap), .status0In(status0In), .status1In(status1In),
    .syncAssert(syncAssert), .holdoverActive(holdoverActive),
    .activeInput(activeInput), .trackedDacCount(trackedDacCount),
    .readbackOut(readbackOut), .lockPinOut(lockPinOut),
    .lockPinOe(lockPinOe), .holdoverPinOut(holdoverPinOut),
    .holdoverPinOe(holdoverPinOe), .status0Out(status0Out),
    .status0Oe(status0Oe), .status1Out(status1Out),
    .status1Oe(status1Oe), .lossOfSignal(lossOfSignal));
  board_model board_model_i (
    .clk_sys(clk_sys), .run(run), .selLevel(selLevel),
    .status0Out(status0Out), .status0Oe(status0Oe),
    .status1Out(status1Out), .status1Oe(status1Oe),
    .refClkIn(refClkIn), .status0In(status0In), .status1In(status1In));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task final_report;
    begin
      $display("Compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input [79:0] what);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("Error %0s expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task cyc(input integer c);
    repeat (c) @(negedge clk_sys);
  endtask
  // Only a word of 32 or more clocks is committed; shorter ones probe that.
  task wr(input [31:0] w, input integer nb);
    integer b;
    begin
      for (b = nb - 1; b >= 0; b = b - 1) begin
        cfgData = w[b];
        cyc(4);
        rbSeen = {rbSeen[30:0], readbackOut};
        cfgClk = 1'b1;
        cyc(4);
        cfgClk = 1'b0;
      end
      cyc(4);
      cfgLatch = 1'b1;
      cyc(4);
      cfgLatch = 1'b0;
      cyc(8);
    end
  endtask
  task wait_idx(input [1:0] e);
    begin
      for (k = 0; k < 60 && activeInput !== e; k = k + 1)
        cyc(1);
      chk(activeInput, e, "input");
      if (k == 60)
        final_report;
    end
  endtask
  function [31:0] lw(input [4:0] s, input [2:0] t, input [1:0] f,
    input trk, input [1:0] h);
    lw = {s, t, f, 13'h0, trk, h, 1'b0, 5'h0c};
  endfunction
  function [31:0] pw(input [2:0] t0, input [2:0] s0, input dis,
    input [2:0] m, input pol, input [2:0] en);
    pw = {5'h04, 3'h3, 5'h00, t0, dis, s0, m, pol, en, 5'h0d};
  endfunction
  function [31:0] lsw(input [1:0] to, input en);
    lsw = {to, 1'b0, en, 23'h0, 5'h0e};
  endfunction
  function [1:0] pin(input [2:0] t, input v);
    case (t)
      3'h3: pin = {1'b1, v};
      3'h4: pin = {1'b1, ~v};
      3'h5: pin = {v, 1'b1};
      3'h6: pin = {~v, 1'b0};
      default: pin = 2'b00;
    endcase
  endfunction
  function mux(input [4:0] c);
    case (c)
      5'h01: mux = loop1Lock;
      5'h02: mux = loop2Lock;
      5'h03: mux = loop1Lock & loop2Lock;
      5'h05: mux = dacLocked;
      5'h08: mux = dacRail;
      5'h09: mux = dacLow;
      5'h0a: mux = dacHigh;
      5'h0b: mux = tap[0];
      5'h0c: mux = half[0];
      5'h0d: mux = tap[1];
      5'h0e: mux = half[1];
      5'h0f: mux = tap[2];
      5'h10: mux = half[2];
      5'h11: mux = tap[3];
      5'h12: mux = half[3];
      default: mux = 1'b0;
    endcase
  endfunction
  initial begin
    repeat (100000) @(posedge clk_sys);
    error_cnt = error_cnt + 1;
    final_report;
  end
  initial begin
    seed = 65267;
    error_cnt = 0;
    n_compared = 0;
    losLim[0] = 120;
    losLim[1] = 21;
    losLim[2] = 6;
    losLim[3] = 3;
    {rst_n, cfgClk, cfgData, cfgLatch, loop1Lock, loop2Lock} = 6'h0;
    {dacLocked, dacRail, dacLow, dacHigh, tune, tap} = 18'h0;
    half = 4'h0;
    run = 3'h7;
    selLevel = 2'h0;
    cyc(12);
    chk({lockPinOe, holdoverPinOe, syncAssert}, 0, "reset");
    rst_n = 1'b1;
    {loop1Lock, loop2Lock} = 2'b11;
    cyc(6);
    chk({lockPinOe, lockPinOut}, 2'b11, "lock pin");
    // The holdover pin keeps source 4, so loop-two R sources are legal here.
    for (j = 3; j < 7; j = j + 1)
      for (i = 0; i < 19; i = i + 1)
        if (i != 6 && i != 7) begin
          r = $random(seed);
          {loop1Lock, loop2Lock, dacLocked, dacRail, dacLow, dacHigh} = r[5:0];
          tune = r[15:6];
          half = half ^ (r[19:16] & ~tap);
          tap = r[19:16];
          wr(lw(i[4:0], j[2:0], 2'b00, 1'b1, 2'h1), 32);
          chk({lockPinOe, lockPinOut}, pin(j[2:0], mux(i[4:0])), "lock");
          chk(trackedDacCount, tune, "dac count");
        end
    wr(lw(5'h0, 3'h3, 2'b00, 1'b0, 2'h1), 32);
    chk(rbSeen, {8'h0, tune, 14'h0}, "readback");
    old = tune;
    tune = ~tune;
    cyc(4);
    chk(trackedDacCount, old, "dac off");
    // Sync qualification lives elsewhere and stays cleared meanwhile.
    for (j = 1; j < 4; j = j + 1) begin
      wr(lw(5'h0, 3'h3, j[1:0], 1'b1, 2'h1), 32);
      for (i = 0; i < 4; i = i + 1) begin
        {loop1Lock, loop2Lock} = i[1:0];
        cyc(3);
        chk(syncAssert, (j[1] & ~loop2Lock) | (j[0] & ~loop1Lock), "sync");
      end
    end
    wr(lw(5'h0, 3'h3, 2'b00, 1'b1, 2'h2), 32);
    for (j = 0; j < 7; j = j + 1) begin
      r = $random(seed);
      dacLocked = r[0];
      wr(pw(j[2:0], 3'h3, 1'b1, 3'h0, 1'b0, 3'h7), 32);
      chk({status0Oe, status0Out}, pin(j[2:0], dacLocked), "status0");
    end
    for (j = 0; j < 3; j = j + 1) begin
      wr(pw(3'h3, 3'h0, j == 1, 3'h0, 1'b0, 3'h7), 32);
      if (j == 2)
        wr(lw(5'h0, 3'h3, 2'b00, 1'b1, 2'h1), 32);
      loop1Lock = 1'b1;
      cyc(3);
      old = trackedDacCount;
      loop1Lock = 1'b0;
      cyc(1);
      tune = tune + 10'h1;
      cyc(2);
      chk({holdoverActive, holdoverPinOut}, {2{j == 0}}, "holdover");
      if (j == 0)
        chk(trackedDacCount, old, "frozen");
    end
    loop1Lock = 1'b1;
    cyc(3);
    chk(holdoverActive, 0, "hold off");
    for (i = 0; i < 3; i = i + 1) begin
      wr(pw(3'h3, 3'h0, 1'b1, i[2:0], 1'b0, 3'h7), 32);
      chk(activeInput, i, "manual");
    end
    // Lock-loss switching stays off while the pins choose the input.
    for (i = 0; i < 2; i = i + 1) begin
      selLevel = 2'b10;
      wr(pw(3'h0, 3'h0, 1'b1, 3'h3, i[0], 3'h7), 32);
      chk(activeInput, 2 - i, "pin sel");
    end
    wr(pw(3'h3, 3'h0, 1'b1, 3'h0, 1'b0, 3'h7), 32);
    wr(lsw(2'h3, 1'b1), 32);
    wr(pw(3'h3, 3'h0, 1'b1, 3'h4, 1'b0, 3'b011), 32);
    run = 3'b110;
    wait_idx(2'h1);
    run = 3'b101;
    wait_idx(2'h0);
    run = 3'h7;
    wr(pw(3'h0, 3'h0, 1'b1, 3'h6, 1'b0, 3'h7), 32);
    run = 3'b110;
    wait_idx(2'h2);
    run = 3'h7;
    for (i = 0; i < 4; i = i + 1) begin
      wr(lsw(i[1:0], 1'b1), 32);
      run = 3'b110;
      for (n = 0; n < 200 && lossOfSignal[0] !== 1'b1; n = n + 1)
        cyc(1);
      chk(n >= losLim[i] && n <= losLim[i] + 8, 1, "los time");
      if (n == 200)
        final_report;
      run = 3'h7;
      cyc(6);
      chk(lossOfSignal, 0, "los clear");
    end
    wr(lsw(2'h3, 1'b0), 32);
    run = 3'b110;
    cyc(140);
    chk(lossOfSignal, 0, "los off");
    run = 3'h7;
    dacLocked = 1'b1;
    wr(lw(5'h0, 3'h3, 2'b00, 1'b1, 2'h1), 32);
    wr(lw(5'h05, 3'h3, 2'b00, 1'b1, 2'h1), 31);
    cyc(4);
    chk({lockPinOe, lockPinOut}, 2'b10, "partial");
    final_report;
  end
endmodule // tb_top
